// [core/ascii_param_pkg.sv]
// Shared constants and carrier types for the ASCII parameter serial slave
package ascii_param_pkg;
  // Control characters on the link
  localparam logic [6:0] CH_STX = 7'h02;
  localparam logic [6:0] CH_ETX = 7'h03;
  localparam logic [6:0] CH_EOT = 7'h04;
  localparam logic [6:0] CH_ENQ = 7'h05;
  localparam logic [6:0] CH_ACK = 7'h06;
  localparam logic [6:0] CH_BS = 7'h08;
  localparam logic [6:0] CH_NAK = 7'h15;
  // Printable characters of the data field, and the checksum floor
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_NINE = 7'h39;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_POINT = 7'h2E;
  localparam logic [6:0] CSUM_FLOOR = 7'h20;
  // Field limits
  localparam logic [3:0] FIELD_MAX = 4'hC;
  localparam logic [3:0] DIGIT_MAX = 4'hA;
  localparam logic [3:0] FRAC_MAX = 4'h9;
  localparam logic [3:0] RADIX = 4'hA;
  localparam int NUM_DIGITS = 10;
  localparam int ACC_W = 56;
  localparam logic [35:0] POS_LIMIT = 36'h07FFFFFFF;
  localparam logic [35:0] NEG_LIMIT = 36'h080000000;
  // Character framing and timing, and the reply layout
  localparam int BASE_BAUD = 300;
  localparam logic [3:0] UART_LAST_BIT = 4'hA;
  localparam logic [5:0] BCD_STEPS = 6'h20;
  localparam logic [4:0] MSG_HEAD = 5'h05;

  typedef struct packed {
    logic [6:0] menu;
    logic [6:0] param;
  } param_sel_t;

  typedef struct packed {
    logic exists;
    logic [2:0] dp;
    logic signed [31:0] value;
    logic signed [31:0] min;
    logic signed [31:0] max;
  } param_info_t;

  typedef struct packed {
    logic valid;
    param_sel_t sel;
    logic signed [31:0] value;
  } param_wr_t;
endpackage

// [core/ascii_param_serial_slave.sv]
// ASCII parameter serial slave: 7E1 UART, command decoder and reply formatter
`timescale 1ns/1ps
`default_nettype none
module ascii_param_serial_slave #(
  parameter int CLK_HZ = 40_000_000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial line and driver enable
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  // Configuration: baud select and two BCD station digits
  input wire logic [2:0] i_baud_sel,
  input wire logic [7:0] i_station_id,
  // Parameter store
  output ascii_param_pkg::param_sel_t o_sel,
  input wire ascii_param_pkg::param_info_t i_info,
  output ascii_param_pkg::param_wr_t o_wr
);
  localparam int CNT_W = $clog2(CLK_HZ / ascii_param_pkg::BASE_BAUD + 1);

  typedef enum logic [4:0] {
    S_IDLE, S_A1A, S_A1B, S_A2A, S_A2B, S_HEAD, S_M1, S_M2, S_P1, S_P2,
    S_ENQ, S_DATA, S_CSUM, S_LOOK, S_SCALE, S_DECIDE, S_BCD, S_SEND
  } state_t;

  state_t state;
  logic rx_busy, rx_vld, rx_err, tx_busy, tx_go;
  logic [CNT_W-1:0] rx_cnt, tx_cnt, div;
  logic [3:0] rx_bit, tx_bit;
  logic [7:0] rx_sh;
  logic [6:0] rx_data, tx_char, ch, xsum, msg_char;
  logic [9:0] tx_sh;
  logic [3:0] a1, a2, d0, d1, d2, d3;
  logic is_wr, reply_en, single, csum_ok;
  logic nonspace, sgn_seen, neg, pt_seen, bad;
  logic [3:0] ndig, nfrac, nchar, ndigits, blen, bidx;
  logic [35:0] acc;
  logic signed [ascii_param_pkg::ACC_W-1:0] sv;
  logic [31:0] bin;
  logic [39:0] bcd, bcd_adj;
  logic [5:0] step;
  logic [4:0] pos;
  logic [2:0] dp;
  logic msg_neg;

  function automatic logic is_digit(input logic [6:0] c);
    return c >= ascii_param_pkg::CH_ZERO && c <= ascii_param_pkg::CH_NINE;
  endfunction

  function automatic logic [3:0] dval(input logic [6:0] c);
    return 4'(c - ascii_param_pkg::CH_ZERO);
  endfunction

  function automatic logic [6:0] dchar(input logic [3:0] d);
    return ascii_param_pkg::CH_ZERO + {3'h0, d};
  endfunction

  // Lift control codes out of the checksum character
  function automatic logic [6:0] csum_fix(input logic [6:0] x);
    return (x < ascii_param_pkg::CSUM_FLOOR) ? x + ascii_param_pkg::CSUM_FLOOR : x;
  endfunction

  // One double-dabble correction over all BCD digits
  function automatic logic [39:0] dabble(input logic [39:0] b);
    logic [39:0] r;
    r = b;
    for (int i = 0; i < ascii_param_pkg::NUM_DIGITS; i++)
    begin
      if (r[i*4+:4] > 4'h4)
        r[i*4+:4] = r[i*4+:4] + 4'h3;
    end
    return r;
  endfunction

  // Rates are 300 doubled per select step, so the divisor is one division
  assign div = CNT_W'(CLK_HZ / (ascii_param_pkg::BASE_BAUD << i_baud_sel));
  assign bcd_adj = dabble(bcd);
  assign ch = rx_data;

  // Receiver: checks start at mid bit, shifts data and parity, checks stop
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_vld <= 1'b0;
      rx_err <= 1'b0;
      rx_data <= 7'h00;
    end
    else
    begin
      rx_vld <= 1'b0;
      if (!rx_busy)
      begin
        if (!i_rxd)
        begin
          rx_busy <= 1'b1;
          rx_cnt <= div >> 1;
          rx_bit <= 4'h0;
        end
      end
      else if (rx_cnt != '0)
        rx_cnt <= rx_cnt - 1'b1;
      else
      begin
        rx_cnt <= div - 1'b1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && i_rxd)
          rx_busy <= 1'b0; // Glitch, not a start bit
        else if (rx_bit == ascii_param_pkg::UART_LAST_BIT - 4'h1)
        begin
          // Judged at the stop bit's centre, so a start that follows at once is not missed
          rx_busy <= 1'b0;
          rx_vld <= 1'b1;
          rx_data <= rx_sh[6:0];
          rx_err <= !i_rxd || (^rx_sh);
        end
        else if (rx_bit != 4'h0)
          rx_sh <= {i_rxd, rx_sh[7:1]};
      end
    end
  end

  // Transmitter: frame is start, data LSB first, even parity, stop
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_busy <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_cnt <= '0;
      tx_bit <= 4'h0;
    end
    else if (!tx_busy)
    begin
      if (tx_go)
      begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, ^tx_char, tx_char, 1'b0};
        tx_cnt <= div - 1'b1;
        tx_bit <= 4'h0;
      end
    end
    else if (tx_cnt != '0)
      tx_cnt <= tx_cnt - 1'b1;
    else
    begin
      tx_cnt <= div - 1'b1;
      tx_bit <= tx_bit + 4'h1;
      tx_sh <= {1'b1, tx_sh[9:1]};
      if (tx_bit == ascii_param_pkg::UART_LAST_BIT - 4'h1)
        tx_busy <= 1'b0;
    end
  end

  assign o_txd = tx_sh[0];
  assign o_txd_oe = tx_busy;

  // Reply body layout: digit count never drops below decimals plus one
  always_comb
  begin
    ndigits = 4'h1;
    for (int i = 0; i < ascii_param_pkg::NUM_DIGITS; i++)
    begin
      if (bcd[i*4+:4] != 4'h0)
        ndigits = 4'(i + 1);
    end
    if (ndigits < {1'b0, dp} + 4'h1)
      ndigits = {1'b0, dp} + 4'h1;
    blen = ndigits + {3'h0, dp != 3'h0};
    bidx = 4'(pos - ascii_param_pkg::MSG_HEAD - 5'h1);
    if (dp != 3'h0 && bidx > ndigits - {1'b0, dp})
      bidx = bidx - 4'h1;
    msg_char = ascii_param_pkg::CH_STX;
    if (single)
      msg_char = tx_char;
    else if (pos == 5'h0)
      msg_char = ascii_param_pkg::CH_STX;
    else if (pos == 5'h1)
      msg_char = dchar(d0);
    else if (pos == 5'h2)
      msg_char = dchar(d1);
    else if (pos == 5'h3)
      msg_char = dchar(d2);
    else if (pos == 5'h4)
      msg_char = dchar(d3);
    else if (pos == ascii_param_pkg::MSG_HEAD)
      msg_char = msg_neg ? ascii_param_pkg::CH_MINUS : ascii_param_pkg::CH_PLUS;
    else if (pos == ascii_param_pkg::MSG_HEAD + 5'(blen) + 5'h1)
      msg_char = ascii_param_pkg::CH_ETX;
    else if (pos == ascii_param_pkg::MSG_HEAD + 5'(blen) + 5'h2)
      msg_char = csum_fix(xsum);
    else if (dp != 3'h0 && pos == ascii_param_pkg::MSG_HEAD + 5'(ndigits - {1'b0, dp}) + 5'h1)
      msg_char = ascii_param_pkg::CH_POINT;
    else
      msg_char = dchar(bcd[(ndigits - 4'h1 - bidx)*4+:4]);
  end

  // Command sequencer: parse, look up, scale, format and reply
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= S_IDLE;
      {a1, a2, d0, d1, d2, d3} <= 24'h000000;
      {is_wr, reply_en, single, csum_ok, msg_neg} <= 5'h00;
      {nonspace, sgn_seen, neg, pt_seen, bad} <= 5'h00;
      {ndig, nfrac, nchar} <= 12'h000;
      acc <= 36'h000000000;
      sv <= '0;
      bin <= 32'h00000000;
      bcd <= 40'h0000000000;
      step <= 6'h00;
      pos <= 5'h00;
      dp <= 3'h0;
      xsum <= 7'h00;
      tx_go <= 1'b0;
      tx_char <= 7'h00;
      o_sel <= '0;
      o_wr <= '0;
    end
    else
    begin
      tx_go <= 1'b0;
      o_wr.valid <= 1'b0;
      if (rx_vld && state <= S_CSUM && (rx_err || ch == ascii_param_pkg::CH_EOT))
        state <= rx_err ? S_IDLE : S_A1A;
      else if (rx_vld && state <= S_CSUM)
      begin
        unique case (state)
          S_IDLE: state <= S_IDLE;
          S_A1A: begin a1 <= dval(ch); state <= is_digit(ch) ? S_A1B : S_IDLE; end
          S_A1B: state <= (is_digit(ch) && dval(ch) == a1) ? S_A2A : S_IDLE;
          S_A2A: begin a2 <= dval(ch); state <= is_digit(ch) ? S_A2B : S_IDLE; end
          S_A2B:
          begin
            reply_en <= a1 == i_station_id[7:4] && a2 == i_station_id[3:0];
            if (!is_digit(ch) || dval(ch) != a2)
              state <= S_IDLE;
            else if ((a1 == i_station_id[7:4] && (a2 == i_station_id[3:0] || a2 == 4'h0))
                     || (a1 == 4'h0 && a2 == 4'h0))
              state <= S_HEAD;
            else
              state <= S_IDLE;
          end
          S_HEAD:
          begin
            is_wr <= ch == ascii_param_pkg::CH_STX;
            {nonspace, sgn_seen, neg, pt_seen, bad} <= 5'h00;
            {ndig, nfrac, nchar} <= 12'h000;
            acc <= 36'h000000000;
            xsum <= (ch == ascii_param_pkg::CH_STX) ? 7'h00 : ch;
            d0 <= dval(ch);
            if (ch == ascii_param_pkg::CH_STX)
              state <= S_M1;
            else
              state <= is_digit(ch) ? S_M2 : S_IDLE;
          end
          S_M1: begin d0 <= dval(ch); xsum <= xsum ^ ch; state <= is_digit(ch) ? S_M2 : S_IDLE; end
          S_M2: begin d1 <= dval(ch); xsum <= xsum ^ ch; state <= is_digit(ch) ? S_P1 : S_IDLE; end
          S_P1: begin d2 <= dval(ch); xsum <= xsum ^ ch; state <= is_digit(ch) ? S_P2 : S_IDLE; end
          S_P2:
          begin
            d3 <= dval(ch);
            xsum <= xsum ^ ch;
            o_sel.menu <= 7'(d0 * ascii_param_pkg::RADIX + d1);
            o_sel.param <= 7'(d2 * ascii_param_pkg::RADIX + dval(ch));
            if (!is_digit(ch))
              state <= S_IDLE;
            else
              state <= is_wr ? S_DATA : S_ENQ;
          end
          S_ENQ: state <= (ch == ascii_param_pkg::CH_ENQ) ? S_LOOK : S_IDLE;
          S_DATA:
          begin
            xsum <= xsum ^ ch;
            if (ch == ascii_param_pkg::CH_ETX)
              state <= S_CSUM;
            else
            begin
              if (nchar == ascii_param_pkg::FIELD_MAX)
                bad <= 1'b1;
              else
                nchar <= nchar + 4'h1;
              if (ch != ascii_param_pkg::CH_SPACE)
                nonspace <= 1'b1;
              if (ch == ascii_param_pkg::CH_SPACE)
                bad <= bad | nonspace;
              else if (ch == ascii_param_pkg::CH_PLUS || ch == ascii_param_pkg::CH_MINUS)
              begin
                bad <= bad | sgn_seen | pt_seen | (ndig != 4'h0);
                sgn_seen <= 1'b1;
                neg <= ch == ascii_param_pkg::CH_MINUS;
              end
              else if (ch == ascii_param_pkg::CH_POINT)
              begin
                bad <= bad | pt_seen;
                pt_seen <= 1'b1;
              end
              else if (is_digit(ch) && ndig != ascii_param_pkg::DIGIT_MAX)
              begin
                acc <= 36'(acc * ascii_param_pkg::RADIX + dval(ch));
                ndig <= ndig + 4'h1;
                nfrac <= nfrac + {3'h0, pt_seen};
              end
              else
                bad <= 1'b1;
            end
          end
          S_CSUM:
          begin
            csum_ok <= ch == csum_fix(xsum);
            state <= S_LOOK;
          end
          default: state <= S_IDLE;
        endcase
      end
      else
      begin
        unique case (state)
          S_LOOK:
          begin
            dp <= i_info.dp;
            pos <= 5'h00;
            if (is_wr)
            begin
              sv <= neg ? -ascii_param_pkg::ACC_W'(acc) : ascii_param_pkg::ACC_W'(acc);
              if (nfrac > ascii_param_pkg::FRAC_MAX || ndig == 4'h0
                  || acc > (neg ? ascii_param_pkg::NEG_LIMIT : ascii_param_pkg::POS_LIMIT))
                bad <= 1'b1;
              state <= S_SCALE;
            end
            else if (!i_info.exists)
            begin
              single <= 1'b1;
              tx_char <= ascii_param_pkg::CH_EOT;
              state <= S_SEND;
            end
            else
            begin
              single <= 1'b0;
              msg_neg <= i_info.value < 0;
              bin <= (i_info.value < 0) ? 32'(-i_info.value) : i_info.value;
              bcd <= 40'h0000000000;
              step <= 6'h00;
              xsum <= 7'h00;
              state <= S_BCD;
            end
          end
          S_SCALE:
          begin
            // Drop or append decimals one per cycle, at most ten cycles
            if (nfrac > {1'b0, dp})
            begin
              // Signed divisor keeps negative values truncating toward zero
              sv <= sv / $signed(ascii_param_pkg::ACC_W'(ascii_param_pkg::RADIX));
              nfrac <= nfrac - 4'h1;
            end
            else if (nfrac < {1'b0, dp})
            begin
              sv <= ascii_param_pkg::ACC_W'(sv * ascii_param_pkg::ACC_W'(ascii_param_pkg::RADIX));
              nfrac <= nfrac + 4'h1;
            end
            else
              state <= S_DECIDE;
          end
          S_DECIDE:
          begin
            single <= 1'b1;
            if (!bad && csum_ok && i_info.exists && sv >= i_info.min && sv <= i_info.max)
            begin
              o_wr.valid <= 1'b1;
              o_wr.sel <= o_sel;
              o_wr.value <= 32'(sv);
              tx_char <= ascii_param_pkg::CH_ACK;
            end
            else
              tx_char <= ascii_param_pkg::CH_NAK;
            state <= reply_en ? S_SEND : S_IDLE;
          end
          S_BCD:
          begin
            if (step == ascii_param_pkg::BCD_STEPS)
              state <= S_SEND;
            else
            begin
              bcd <= {bcd_adj[38:0], bin[31]};
              bin <= bin << 1;
              step <= step + 6'h01;
            end
          end
          S_SEND:
          begin
            // Each character waits for the previous frame to finish
            if (!tx_go && !tx_busy)
            begin
              tx_go <= 1'b1;
              tx_char <= msg_char;
              if (pos != 5'h00)
                xsum <= xsum ^ msg_char;
              pos <= pos + 5'h01;
              if (single || pos == ascii_param_pkg::MSG_HEAD + 5'(blen) + 5'h2)
                state <= S_IDLE;
            end
          end
          default: state <= state;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/ascii_param_chk.sv]
// Checker of serial framing and parameter write strobes at the slave's ports
`timescale 1ns/1ps
`default_nettype none
module ascii_param_chk #(
  parameter int CLK_HZ = 40_000_000
) (
  // Clock, reset and serial line
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_txd_oe,
  // Configuration and parameter store
  input wire logic [2:0] i_baud_sel,
  input wire logic [7:0] i_station_id,
  input wire ascii_param_pkg::param_sel_t o_sel,
  input wire ascii_param_pkg::param_info_t i_info,
  input wire ascii_param_pkg::param_wr_t o_wr
);
  logic [23:0] run;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Length of the current driver-enable burst; wide enough for the slowest rate
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      run <= 24'h000000;
    else
      run <= o_txd_oe ? run + 24'h000001 : 24'h000000;

  idle_line_high_a: assert property (!o_txd_oe |-> o_txd)
    else $error("Line not at idle level while the driver is off");
  start_bit_low_a: assert property ($rose(o_txd_oe) |-> !o_txd)
    else $error("Frame does not open with a low start bit");
  stop_bit_high_a: assert property ($fell(o_txd_oe) |-> $past(o_txd))
    else $error("Frame does not close with a high stop bit");
  frame_length_a: assert property ($fell(o_txd_oe) |-> run == 24'(10 * (CLK_HZ / (300 << i_baud_sel))))
    else $error("Frame is not ten bit times long");
  write_pulse_a: assert property (o_wr.valid |=> !o_wr.valid)
    else $error("Write strobe longer than one cycle");
  write_exists_a: assert property (o_wr.valid |-> i_info.exists)
    else $error("Write to a missing parameter");
  write_range_a: assert property (o_wr.valid |-> o_wr.value >= i_info.min && o_wr.value <= i_info.max)
    else $error("Write value outside the parameter range");
  write_target_a: assert property (o_wr.valid |-> o_wr.sel == o_sel)
    else $error("Write target differs from the looked-up parameter");
  value_hold_a: assert property ($changed(o_wr.value) |-> o_wr.valid)
    else $error("Write value changed without a strobe");
  sel_steady_a: assert property (o_txd_oe |-> $stable(o_sel))
    else $error("Parameter selection moved during a reply");
endmodule

bind ascii_param_serial_slave ascii_param_chk #(.CLK_HZ(CLK_HZ)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe),
  .i_baud_sel(i_baud_sel), .i_station_id(i_station_id), .o_sel(o_sel), .i_info(i_info), .o_wr(o_wr)
);
`default_nettype wire

// [testbench/ascii_param_host.sv]
// Host master model: sends 7E1 characters and captures the slave's replies
`timescale 1ns/1ps
`default_nettype none
module ascii_param_host (
  // Clock and bit time in clock cycles
  input wire logic i_clk,
  input wire logic [9:0] i_div,
  // Serial line from and towards the slave
  input wire logic i_txd,
  output var logic o_rxd
);
  // Line rests at the pull-up level between frames
  initial o_rxd = 1'b1;

  // One frame, low bit first; flip spoils the parity bit on purpose
  task automatic send(input logic [6:0] c, input bit flip);
    logic [9:0] f;
    f = {1'b1, (^c) ^ flip, c, 1'b0};
    @(negedge i_clk);
    for (int i = 0; i < 10; i++)
    begin
      o_rxd = f[i];
      repeat (i_div) @(negedge i_clk);
    end
  endtask

  // Bounded wait for a start bit, then mid-cell samples off the launching edge
  task automatic get(output logic [6:0] c, output bit ok);
    logic [9:0] f;
    int n;
    n = 0;
    f = '0;
    while (i_txd !== 1'b0 && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    repeat (i_div / 2) @(negedge i_clk);
    for (int i = 0; i < 10; i++)
    begin
      f[i] = i_txd;
      if (i < 9)
        repeat (i_div) @(negedge i_clk);
    end
    c = f[7:1];
    ok = n < 400 && f[0] === 1'b0 && f[9] === 1'b1 && (^f[8:1]) === 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/ascii_param_serial_slave_test.sv]
// Self-checking bench for the ASCII parameter serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module ascii_param_serial_slave_test;
  // Small clock figure gives four cycles a bit at the top rate
  localparam int CLK_HZ = 153600;
  logic i_clk, i_rst, rxd, txd, txd_oe;
  logic [2:0] baud_sel;
  logic [9:0] div;
  ascii_param_pkg::param_sel_t sel;
  ascii_param_pkg::param_info_t info;
  ascii_param_pkg::param_wr_t wr;
  int error_cnt, n_compared, wr_cnt, n;
  logic [31:0] wr_val;
  logic [6:0] c;
  bit ok;

  assign div = 10'(CLK_HZ / (300 << baud_sel));

  ascii_param_serial_slave #(.CLK_HZ(CLK_HZ)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_rxd(rxd),
    .o_txd(txd), .o_txd_oe(txd_oe), .i_baud_sel(baud_sel), .i_station_id(8'h78),
    .o_sel(sel), .i_info(info), .o_wr(wr));
  ascii_param_host u_host (.i_clk(i_clk), .i_div(div), .i_txd(txd), .o_rxd(rxd));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Count write strobes so each test sees how many landed
  always @(posedge i_clk)
    if (wr.valid === 1'b1)
    begin
      wr_cnt++;
      wr_val = wr.value;
    end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %0h, expected %0h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // XOR from the menu digit through end-of-text, lifted clear of control codes
  function automatic logic [6:0] csum(input string b);
    logic [6:0] x;
    x = ascii_param_pkg::CH_ETX;
    for (int i = 0; i < b.len(); i++)
      x ^= 7'(b[i]);
    return (x < 7'h20) ? x + 7'h20 : x;
  endfunction

  task automatic put(input string s);
    for (int i = 0; i < s.len(); i++)
      u_host.send(7'(s[i]), 1'b0);
  endtask

  // Start of request with each station digit sent twice
  task automatic hdr(input string ad);
    u_host.send(ascii_param_pkg::CH_EOT, 1'b0);
    for (int i = 0; i < 2; i++)
      repeat (2) u_host.send(7'(ad[i]), 1'b0);
  endtask

  task automatic req_r(input string ad, input string mp);
    hdr(ad);
    put(mp);
    u_host.send(ascii_param_pkg::CH_ENQ, 1'b0);
  endtask

  task automatic req_w(input string ad, input string b, input logic [6:0] bad);
    hdr(ad);
    u_host.send(ascii_param_pkg::CH_STX, 1'b0);
    put(b);
    u_host.send(ascii_param_pkg::CH_ETX, 1'b0);
    u_host.send(csum(b) ^ bad, 1'b0);
  endtask

  task automatic exp1(input logic [6:0] e);
    u_host.get(c, ok);
    `CHK(ok, 1'b1);
    `CHK(c, e);
  endtask

  // Silence: nothing may start within the wait window
  task automatic exp_none;
    u_host.get(c, ok);
    `CHK(ok, 1'b0);
  endtask

  task automatic exp_msg(input string b);
    exp1(ascii_param_pkg::CH_STX);
    for (int i = 0; i < b.len(); i++)
      exp1(7'(b[i]));
    exp1(ascii_param_pkg::CH_ETX);
    exp1(csum(b));
  endtask

  // Store answer with a fixed range of plus or minus 100000
  task automatic set_info(input bit ex, input logic [2:0] dp, input logic [31:0] v);
    info = '{exists: ex, dp: dp, value: v, min: 32'hFFFE7960, max: 32'h000186A0};
  endtask

  task automatic t_read;
    string f[7] = '{"+1.2", "-345.78", "+0.00", "+0", "+123456", "-2147483648", "+2147.483647"};
    logic [31:0] v[7] = '{32'hC, 32'hFFFF78EE, 32'h0, 32'h0, 32'h1E240, 32'h80000000, 32'h7FFFFFFF};
    logic [2:0] d[7] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h6};
    for (int i = 0; i < 7; i++)
    begin
      set_info(1'b1, d[i], v[i]);
      req_r("78", "0102");
      exp_msg({"0102", f[i]});
      `CHK(sel, 14'h0082);
    end
    set_info(1'b0, 3'h0, 32'h0);
    req_r("78", "1299");
    exp1(ascii_param_pkg::CH_EOT);
    `CHK(sel, {7'h0C, 7'h63});
    $display("Test of read replies done");
  endtask

  task automatic t_write;
    string b[9] = '{"+1.2345", " 1.2", "  -7", "-1.25", "1 2", "200000", "12345678901", "2147483648", ".1234567890"};
    logic [2:0] d[9] = '{3'h1, 3'h3, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [31:0] v[9] = '{32'hC, 32'h4B0, 32'hFFFFFFF9, 32'hFFFFFFF4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    bit ack[9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      set_info(1'b1, d[i], 32'h0);
      n = wr_cnt;
      req_w("78", {"0102", b[i]}, 7'h00);
      exp1(ack[i] ? ascii_param_pkg::CH_ACK : ascii_param_pkg::CH_NAK);
      `CHK(wr_cnt - n, ack[i]);
      if (ack[i])
        `CHK(wr_val, v[i]);
    end
    n = wr_cnt;
    req_w("78", "0102+5", 7'h01);
    exp1(ascii_param_pkg::CH_NAK);
    set_info(1'b0, 3'h0, 32'h0);
    req_w("78", "0102+5", 7'h00);
    exp1(ascii_param_pkg::CH_NAK);
    `CHK(wr_cnt - n, 0);
    $display("Test of writes done");
  endtask

  task automatic t_addr;
    set_info(1'b1, 3'h0, 32'h9);
    n = wr_cnt;
    req_w("70", "0102+9", 7'h00);
    exp_none();
    req_w("00", "0102-9", 7'h00);
    exp_none();
    `CHK(wr_cnt - n, 2);
    `CHK(wr_val, 32'hFFFFFFF7);
    `CHK(wr.sel, 14'h0082);
    req_r("00", "0102");
    exp_msg("0102+9");
    req_r("75", "0102");
    exp_none();
    $display("Test of addressing done");
  endtask

  // Rate changes wait for a quiet line, so no frame straddles two rates
  task automatic set_rate(input logic [2:0] s);
    wait (txd_oe === 1'b0);
    repeat (2) @(negedge i_clk);
    baud_sel = s;
  endtask

  // Parity fault in mid-request, then a rate change
  task automatic t_fault;
    set_info(1'b1, 3'h0, 32'h3);
    hdr("78");
    u_host.send(7'h30, 1'b1);
    put("102");
    u_host.send(ascii_param_pkg::CH_ENQ, 1'b0);
    exp_none();
    req_r("78", "0102");
    exp_msg("0102+3");
    set_rate(3'h5);
    set_info(1'b1, 3'h1, 32'hFFFFFFF3);
    req_r("78", "0102");
    exp_msg("0102-1.3");
    set_rate(3'h7);
    $display("Test of faults and rates done");
  endtask

  initial
  begin
    i_rst = 1'b1;
    baud_sel = 3'h7;
    info = '0;
    error_cnt = 0;
    n_compared = 0;
    wr_cnt = 0;
    wr_val = '0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    t_read();
    t_write();
    t_addr();
    t_fault();
    close_out();
  end

  // Watchdog: the tests need about 25k cycles, so 90k means a hang
  initial
  begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
